// >>> dbg_pkg.sv
// Constants for the background debug status and command-decode block.
// Assumes a single 100 MHz core clock and synchronous active-high reset.
package dbg_pkg;
	localparam logic [15:0] CMD_REG_ADDR = 16'hff00;
	localparam logic [15:0] STAT_REG_ADDR = 16'hff01;
	localparam logic [15:0] DBG_MAP_LO = 16'hff00;
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [7:0] ENTER_BACKGROUND_REQUEST_CODE = 8'h90;
	// Command register fields
	localparam int CMD_HW_BIT = 7;
	localparam int CMD_DATA_BIT = 6;
	localparam int CMD_READ_BIT = 5;
	localparam int CMD_ENTER_BACKGROUND_REQUEST_BIT = 4;
	localparam int CMD_WORD_BIT = 3;
	localparam int CMD_MAP_BIT = 2;
	localparam int STR_HI = 4;
	localparam int STR_LO = 3;
	localparam int TGT_HI = 2;
	localparam int TGT_LO = 0;
	// Status register fields
	localparam int ST_PERMIT = 7;
	localparam int ST_ACTIVE = 6;
	localparam int ST_TAG = 5;
	localparam int ST_SDV = 4;
	localparam int ST_STEP = 3;
	localparam int ST_CLKSEL = 2;
	// Timing
	localparam int ACTIVE_WR_DELAY = 4;
	localparam int TAG_DELAY = 16;
	localparam int IDLE_TIMEOUT = 512;
	localparam logic [15:0] NEXT_INCR = 16'h0002;
	typedef enum logic [1:0] {
		STR_NONE = 2'b00,
		STR_RESUME = 2'b01,
		STR_STEP = 2'b10,
		STR_TAG = 2'b11
	} step_tag_resume_t;
	typedef enum logic [2:0] {
		TGT_UNUSED0 = 3'b000,
		TGT_UNUSED1 = 3'b001,
		TGT_NEXT = 3'b010,
		TGT_PC = 3'b011,
		TGT_D = 3'b100,
		TGT_X = 3'b101,
		TGT_Y = 3'b110,
		TGT_SP = 3'b111
	} target_t;
endpackage

// >>> dbg_delay.sv
// Countdown that emits a pulse a fixed number of cycles after a start.
// Assumes start pulses; a new start restarts the count.
`timescale 1ns/1ps
`default_nettype none
module dbg_delay #(
	parameter int CYCLES = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic start,
	output logic done
);
	localparam int W = $clog2(CYCLES + 1);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;
	initial begin
		if (CYCLES < 1) $error("dbg_delay: CYCLES must be at least 1");
	end
	assign nxt_cnt = start ? W'(CYCLES) :
		(cnt_ff != '0) ? cnt_ff - W'(1) : cnt_ff;
	assign done = (cnt_ff == W'(1));
	always_ff @(posedge clk) begin
		if (rst) cnt_ff <= '0;
		else cnt_ff <= nxt_cnt;
	end
endmodule
`default_nettype wire

// >>> dbg_buf2.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock; the drain side may stall at any time.
`timescale 1ns/1ps
`default_nettype none
module dbg_buf2 #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_ff [2];
	logic wp_ff;
	logic rp_ff;
	logic [1:0] cnt_ff;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	initial begin
		if (WIDTH < 1) $error("dbg_buf2: WIDTH must be positive");
	end
	assign in_ready = (cnt_ff != 2'h2);
	assign out_valid = (cnt_ff != 2'h0);
	assign out_data = mem_ff[rp_ff];
	always_ff @(posedge clk) begin
		if (push) mem_ff[wp_ff] <= in_data;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			wp_ff <= 1'b0;
			rp_ff <= 1'b0;
			cnt_ff <= 2'h0;
		end else begin
			if (push) wp_ff <= ~wp_ff;
			if (pop) rp_ff <= ~rp_ff;
			cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule
`default_nettype wire

// >>> dbg_cmd_decode.sv
// Status register, command register and command decode of the
// single-pin background debug interface.
// Assumes the serial shifter, bit timing and breakpoint logic sit outside
// and are reached through the shift-done, edge and strobe ports.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RULE_01] Permit 0 blocks active debug entry; hardware commands still run.
// [RULE_02] Entry sets active flag and maps debug ROM; clearing it unmaps.
// [RULE_03] Writes to the active flag take effect four cycles later.
// [RULE_04] Tag-arm set by tag-and-resume, cleared on active debug entry.
// [RULE_05] Sixteen cycles after tag-arm write: serial off, tagging on.
// [RULE_06] While tagging, no serial debug commands are processed.
// [RULE_07] Shifter-valid reads 1 after a completed shift, 0 meanwhile.
// [RULE_08] Single-step flag asserts whenever single-step command executes.
// [RULE_09] Clock select 0 picks debug clock, 1 picks bus clock.
// [RULE_10] Host times data and next 150 cycles at the old clock rate.
// [RULE_11] New link clock governs from start of the next command.
// [RULE_12] Bus clock slower than debug clock forces bus clock use.
// [RULE_13] Command register loads from serial; bus access in peripheral mode.
// [RULE_14] 512 debug clock cycles between host falling edges clear it.
// [RULE_15] Command bit 7: 0 firmware, 1 hardware command.
// [RULE_16] Bit 6 set means data follows; bit 5 set read, clear write.
// [RULE_17] Hardware bit 4 requests background entry; code is 90 hex.
// [RULE_18] Hardware bit 3 picks word when 1, byte when 0.
// [RULE_19] Hardware bit 2 picks debug map or user map for FF00-FFFF.
// [RULE_20] Firmware field: none, resume, single step, tag-and-resume.
// [RULE_21] Target field: next, PC, D, X, Y, SP; 000 and 001 unused.
// [RULE_22] Read/write next: increment X by two, then access the word.
// [RULE_23] Active flag writable only by firmware, clock select only hardware.
// [RULE_24] Step field at bits 4:3, target field at bits 2:0.
module dbg_cmd_decode #(
	parameter int IDLE_CYCLES = dbg_pkg::IDLE_TIMEOUT,
	parameter int DATA_W = 16
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// Mode and clock conditions
	input wire logic SPECIAL_PERIPH,
	input wire logic SPECIAL_SINGLE,
	input wire logic BUS_CLK_SLOW,
	// Debug pin activity and serial shifter
	input wire logic DEBUG_PIN_FALL,
	input wire logic DEBUG_CLK_TICK,
	input wire logic CMD_SHIFT_DONE,
	input wire logic [7:0] CMD_SHIFT_DATA,
	input wire logic SHIFT_START,
	input wire logic SHIFT_DONE,
	input wire logic [DATA_W-1:0] SHIFT_DATA,
	// Shift data out to firmware, two-entry buffered
	output logic SHIFT_OUT_VALID,
	input wire logic SHIFT_OUT_READY,
	output logic [DATA_W-1:0] SHIFT_OUT_DATA,
	output logic SHIFT_IN_READY,
	// Parallel register port
	input wire logic [15:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	input wire logic FW_STORE,
	// Entry request from breakpoint or CPU
	input wire logic ENTER_DEBUG,
	input wire logic [15:0] INDEX_X,
	// Decoded outputs
	output logic DEBUG_ACTIVE,
	output logic DEBUG_MAP,
	output logic TAG_ENABLE,
	output logic SERIAL_ENABLE,
	output logic LINK_CLK_BUS,
	output logic CMD_VALID,
	output logic CMD_HW,
	output logic CMD_DATA,
	output logic CMD_READ,
	output logic CMD_WORD,
	output logic ENTER_BACKGROUND_REQUEST,
	output logic DEBUG_MAP_SELECT,
	output logic FW_RESUME,
	output logic FW_SINGLE_STEP,
	output logic FW_TAG_RESUME,
	output logic [2:0] TARGET_REGISTER,
	output logic TARGET_NEXT,
	output logic [15:0] NEXT_ADDR
);
	localparam int IW = $clog2(IDLE_CYCLES + 1);
	initial begin
		if (IDLE_CYCLES < 1) $error("IDLE_CYCLES must be at least 1");
		if (DATA_W < 8) $error("DATA_W must be at least 8");
	end

	// ==============================================
	// Registers
	logic [7:0] cmd_ff;
	logic debug_permit_ff;
	logic debug_active_flag_ff;
	logic tag_arm_flag_ff;
	logic shifter_valid_flag_ff;
	logic step_flag_ff;
	logic link_clock_select_ff;
	logic sel_pending_ff;
	logic pend_active_ff;
	logic tag_on_ff;
	logic cmd_valid_ff;
	logic [IW-1:0] idle_ff;
	logic init_ff;

	// ==============================================
	// Address decode and write qualification
	wire cmd_hit = (REG_ADDR == dbg_pkg::CMD_REG_ADDR);
	wire stat_hit = (REG_ADDR == dbg_pkg::STAT_REG_ADDR);
	wire regs_visible = debug_active_flag_ff || SPECIAL_PERIPH;
	wire stat_wr = REG_WR && stat_hit && regs_visible;
	wire cmd_bus_wr = REG_WR && cmd_hit && SPECIAL_PERIPH; // RULE_13
	wire fw_type = ~cmd_ff[dbg_pkg::CMD_HW_BIT];
	wire active_wr = stat_wr && fw_type; // RULE_23
	wire clksel_wr = stat_wr && ~fw_type; // RULE_23
	wire active_store = FW_STORE && debug_active_flag_ff; // RULE_02

	// ==============================================
	// Command capture and decode
	wire serial_ok = ~tag_on_ff; // RULE_06
	wire cmd_load = CMD_SHIFT_DONE && serial_ok; // RULE_13
	wire idle_expire = DEBUG_CLK_TICK &&
		(idle_ff == IW'(IDLE_CYCLES - 1)); // RULE_14
	wire is_hw = cmd_ff[dbg_pkg::CMD_HW_BIT]; // RULE_15
	wire [1:0] str_field = cmd_ff[dbg_pkg::STR_HI:dbg_pkg::STR_LO]; // RULE_24
	wire [2:0] tgt_field = cmd_ff[dbg_pkg::TGT_HI:dbg_pkg::TGT_LO]; // RULE_24
	wire fw_exec = cmd_valid_ff && ~is_hw && debug_active_flag_ff; // RULE_01
	wire hw_enter_background_request = cmd_valid_ff && (cmd_ff == dbg_pkg::ENTER_BACKGROUND_REQUEST_CODE); // RULE_17
	wire do_step = fw_exec &&
		(str_field == dbg_pkg::STR_STEP); // RULE_20
	wire do_tag = fw_exec && (str_field == dbg_pkg::STR_TAG); // RULE_20
	wire do_resume = fw_exec &&
		(str_field == dbg_pkg::STR_RESUME); // RULE_20
	wire entry = (ENTER_DEBUG || hw_enter_background_request) && debug_permit_ff &&
		~debug_active_flag_ff; // RULE_01

	// ==============================================
	// Delays for active-flag writes and tag arming
	logic active_go;
	logic tag_go;
	wire tag_written = do_tag || (stat_wr && REG_WDATA[dbg_pkg::ST_TAG]);
	dbg_delay #(.CYCLES(dbg_pkg::ACTIVE_WR_DELAY)) u_act_dly (
		.clk(CORE_CLK),
		.rst(RST),
		.start(active_wr || active_store),
		.done(active_go)
	); // RULE_03
	dbg_delay #(.CYCLES(dbg_pkg::TAG_DELAY)) u_tag_dly (
		.clk(CORE_CLK),
		.rst(RST),
		.start(tag_written),
		.done(tag_go)
	); // RULE_05

	// ==============================================
	// Shift data path
	wire buf_in_ready;
	dbg_buf2 #(.WIDTH(DATA_W)) u_buf (
		.clk(CORE_CLK),
		.rst(RST),
		.in_valid(SHIFT_DONE && serial_ok),
		.in_ready(buf_in_ready),
		.in_data(SHIFT_DATA),
		.out_valid(SHIFT_OUT_VALID),
		.out_ready(SHIFT_OUT_READY),
		.out_data(SHIFT_OUT_DATA)
	);
	assign SHIFT_IN_READY = buf_in_ready && serial_ok;

	// ==============================================
	// Next-state logic
	wire [7:0] nxt_cmd = cmd_load ? CMD_SHIFT_DATA :
		cmd_bus_wr ? REG_WDATA :
		idle_expire ? dbg_pkg::CMD_RESET : cmd_ff; // RULE_14
	wire [IW-1:0] nxt_idle = DEBUG_PIN_FALL ? '0 :
		idle_expire ? '0 :
		DEBUG_CLK_TICK ? idle_ff + IW'(1) : idle_ff;
	wire nxt_active = entry ? 1'b1 :
		active_go ? pend_active_ff : debug_active_flag_ff; // RULE_02
	wire nxt_pend = active_store ? 1'b0 :
		active_wr ? REG_WDATA[dbg_pkg::ST_ACTIVE] : pend_active_ff;
	wire nxt_tag_arm = entry ? 1'b0 :
		do_tag ? 1'b1 :
		stat_wr ? REG_WDATA[dbg_pkg::ST_TAG] : tag_arm_flag_ff; // RULE_04
	wire nxt_tag_on = entry ? 1'b0 :
		tag_go ? tag_arm_flag_ff : tag_on_ff; // RULE_05
	// Shift completion wins over a clearing start
	wire nxt_sdv = (SHIFT_DONE && serial_ok) ? 1'b1 :
		(SHIFT_START || (stat_wr && ~REG_WDATA[dbg_pkg::ST_SDV])) ?
		1'b0 : shifter_valid_flag_ff; // RULE_07
	wire nxt_step = do_step ? 1'b1 :
		stat_wr ? REG_WDATA[dbg_pkg::ST_STEP] : step_flag_ff; // RULE_08
	wire nxt_sel_pend = clksel_wr ? REG_WDATA[dbg_pkg::ST_CLKSEL] :
		sel_pending_ff;
	// New selection applied at the start of the next command
	wire nxt_clksel = (SHIFT_START && ~cmd_valid_ff) || cmd_load ?
		sel_pending_ff : link_clock_select_ff; // RULE_11
	wire nxt_permit = stat_wr ? REG_WDATA[dbg_pkg::ST_PERMIT] :
		debug_permit_ff;

	// ==============================================
	// Clocked state
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			cmd_ff <= dbg_pkg::CMD_RESET;
			idle_ff <= '0;
			cmd_valid_ff <= 1'b0;
		end else begin
			cmd_ff <= nxt_cmd;
			idle_ff <= nxt_idle;
			cmd_valid_ff <= cmd_load || cmd_bus_wr;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			debug_active_flag_ff <= 1'b0;
			pend_active_ff <= 1'b0;
			tag_arm_flag_ff <= 1'b0;
			tag_on_ff <= 1'b0;
		end else begin
			debug_active_flag_ff <= nxt_active;
			pend_active_ff <= nxt_pend;
			tag_arm_flag_ff <= nxt_tag_arm;
			tag_on_ff <= nxt_tag_on;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			shifter_valid_flag_ff <= 1'b0;
			step_flag_ff <= 1'b0;
			sel_pending_ff <= 1'b0;
			link_clock_select_ff <= 1'b0;
		end else begin
			shifter_valid_flag_ff <= nxt_sdv;
			step_flag_ff <= nxt_step;
			sel_pending_ff <= nxt_sel_pend;
			link_clock_select_ff <= nxt_clksel;
		end
	end

	// Special single chip shows active only in the first cycle after release; the active flag itself stays clear
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			debug_permit_ff <= 1'b0;
			init_ff <= 1'b1;
		end else begin
			init_ff <= 1'b0;
			debug_permit_ff <= nxt_permit;
		end
	end
	wire boot_active = init_ff && SPECIAL_SINGLE && ~RST;

	// ==============================================
	// Read data
	wire [7:0] status_word = {debug_permit_ff, debug_active_flag_ff,
		tag_arm_flag_ff, shifter_valid_flag_ff, step_flag_ff,
		link_clock_select_ff, 2'b00};
	logic [7:0] rdata_ff;
	wire [7:0] nxt_rdata = ~REG_RD ? rdata_ff :
		(cmd_hit && regs_visible) ? cmd_ff :
		(stat_hit) ? status_word : 8'h00;
	always_ff @(posedge CORE_CLK) begin
		if (RST) rdata_ff <= 8'h00;
		else rdata_ff <= nxt_rdata;
	end
	assign REG_RDATA = rdata_ff;

	// ==============================================
	// Outputs
	assign DEBUG_ACTIVE = debug_active_flag_ff || boot_active; // RULE_02
	assign DEBUG_MAP = DEBUG_ACTIVE; // RULE_02
	assign TAG_ENABLE = tag_on_ff; // RULE_05
	assign SERIAL_ENABLE = serial_ok; // RULE_06
	assign LINK_CLK_BUS = link_clock_select_ff || BUS_CLK_SLOW; // RULE_09 RULE_12
	assign CMD_VALID = cmd_valid_ff;
	assign CMD_HW = is_hw; // RULE_15
	assign CMD_DATA = cmd_ff[dbg_pkg::CMD_DATA_BIT]; // RULE_16
	assign CMD_READ = cmd_ff[dbg_pkg::CMD_READ_BIT]; // RULE_16
	assign CMD_WORD = is_hw && cmd_ff[dbg_pkg::CMD_WORD_BIT]; // RULE_18
	assign ENTER_BACKGROUND_REQUEST = is_hw &&
		cmd_ff[dbg_pkg::CMD_ENTER_BACKGROUND_REQUEST_BIT]; // RULE_17
	assign DEBUG_MAP_SELECT = is_hw &&
		cmd_ff[dbg_pkg::CMD_MAP_BIT]; // RULE_19
	assign FW_RESUME = do_resume; // RULE_20
	assign FW_SINGLE_STEP = do_step; // RULE_08
	assign FW_TAG_RESUME = do_tag; // RULE_04
	assign TARGET_REGISTER = ~is_hw ? tgt_field : 3'h0; // RULE_21
	assign TARGET_NEXT = ~is_hw &&
		(tgt_field == dbg_pkg::TGT_NEXT); // RULE_21
	assign NEXT_ADDR = INDEX_X + dbg_pkg::NEXT_INCR; // RULE_22
endmodule
`default_nettype wire

// >>> dbg_host.sv
// Behavioural model of the external debug host on the debug pin.
// Assumes the bench calls its tasks; strobes change after CORE_CLK edges.
`timescale 1ns/1ps
`default_nettype none
module dbg_host (
	// Clock
	input wire logic CORE_CLK,
	// Pin activity and shifter strobes
	output logic DEBUG_PIN_FALL,
	output logic DEBUG_CLK_TICK,
	output logic CMD_SHIFT_DONE,
	output logic [7:0] CMD_SHIFT_DATA,
	output logic SHIFT_START,
	output logic SHIFT_DONE,
	output logic [15:0] SHIFT_DATA
);
	initial begin
		{DEBUG_PIN_FALL, DEBUG_CLK_TICK, CMD_SHIFT_DONE} = 3'h0;
		{SHIFT_START, SHIFT_DONE} = 2'h0;
		CMD_SHIFT_DATA = 8'h00;
		SHIFT_DATA = 16'h0000;
	end
	// Debug clock periods with the pin quiet
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge CORE_CLK);
			DEBUG_CLK_TICK <= 1'b1;
		end
		@(posedge CORE_CLK);
		DEBUG_CLK_TICK <= 1'b0;
	endtask
	// Command byte framed by a falling edge; gap sets the pace
	task automatic cmd(input logic [7:0] b, input int gap);
		@(posedge CORE_CLK);
		DEBUG_PIN_FALL <= 1'b1;
		@(posedge CORE_CLK);
		DEBUG_PIN_FALL <= 1'b0;
		ticks(gap);
		CMD_SHIFT_DONE <= 1'b1;
		CMD_SHIFT_DATA <= b;
		@(posedge CORE_CLK);
		CMD_SHIFT_DONE <= 1'b0;
		CMD_SHIFT_DATA <= ~b;
	endtask
	// Data word; released lines show the inverse
	task automatic word(input logic [15:0] w, input int gap);
		@(posedge CORE_CLK);
		SHIFT_START <= 1'b1;
		@(posedge CORE_CLK);
		SHIFT_START <= 1'b0;
		ticks(gap);
		SHIFT_DONE <= 1'b1;
		SHIFT_DATA <= w;
		@(posedge CORE_CLK);
		SHIFT_DONE <= 1'b0;
		SHIFT_DATA <= ~w;
	endtask
endmodule
`default_nettype wire

// >>> dbg_cmd_decode_sva.sv
// Concurrent checks on the ports of the debug command-decode block.
// Assumes a bind to dbg_cmd_decode with default data width.
`timescale 1ns/1ps
`default_nettype none
module dbg_cmd_decode_sva (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// Watched inputs
	input wire logic BUS_CLK_SLOW,
	input wire logic CMD_SHIFT_DONE,
	input wire logic [7:0] CMD_SHIFT_DATA,
	input wire logic REG_WR,
	input wire logic FW_STORE,
	input wire logic [15:0] INDEX_X,
	// Watched outputs
	input wire logic DEBUG_ACTIVE,
	input wire logic DEBUG_MAP,
	input wire logic TAG_ENABLE,
	input wire logic SERIAL_ENABLE,
	input wire logic LINK_CLK_BUS,
	input wire logic CMD_VALID,
	input wire logic CMD_HW,
	input wire logic CMD_DATA,
	input wire logic CMD_READ,
	input wire logic FW_SINGLE_STEP,
	input wire logic FW_TAG_RESUME,
	input wire logic [15:0] NEXT_ADDR
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// ========================================
	// Assertions
	map_tracks_active_a: assert property (DEBUG_MAP == DEBUG_ACTIVE)
		else $error("map flag differs from active flag");
	serial_off_a: assert property (SERIAL_ENABLE == !TAG_ENABLE)
		else $error("serial enable not inverse of tagging");
	slow_bus_a: assert property (BUS_CLK_SLOW |-> LINK_CLK_BUS)
		else $error("slow bus clock not forced");
	next_addr_a: assert property (NEXT_ADDR == INDEX_X + 16'h0002)
		else $error("next address not index plus two");
	cmd_decode_a: assert property ($past(CMD_SHIFT_DONE) &&
		!$past(TAG_ENABLE) |-> CMD_VALID && CMD_HW == $past(CMD_SHIFT_DATA[7])
		&& {CMD_DATA, CMD_READ} == $past(CMD_SHIFT_DATA[6:5]))
		else $error("command decode wrong");
	tag_refuse_a: assert property ($past(CMD_SHIFT_DONE) &&
		$past(TAG_ENABLE) && !$past(REG_WR) |-> !CMD_VALID)
		else $error("command taken while tagging");
	tag_delay_a: assert property (FW_TAG_RESUME |->
		!TAG_ENABLE [*8] ##[8:10] TAG_ENABLE)
		else $error("tagging delay wrong");
	active_delay_a: assert property ($fell(DEBUG_ACTIVE) |->
		$past(REG_WR, 4) || $past(REG_WR, 5) || $past(FW_STORE, 5) ||
		$past(RST, 2))
		else $error("active flag cleared without delayed write");
	entry_untag_a: assert property ($rose(DEBUG_ACTIVE) |->
		!TAG_ENABLE)
		else $error("tagging still on after debug entry");
	step_fw_a: assert property (FW_SINGLE_STEP |-> CMD_VALID && !CMD_HW)
		else $error("single step outside firmware command");
endmodule
bind dbg_cmd_decode dbg_cmd_decode_sva dbg_cmd_decode_sva_inst (.*);
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the debug command-decode block.
// Assumes dbg_host drives the pin side and idle limit is set to 8.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic CORE_CLK = 1'b0, RST = 1'b1, SPECIAL_PERIPH = 1'b1;
	logic SPECIAL_SINGLE = 1'b0, BUS_CLK_SLOW = 1'b0, SHIFT_OUT_READY = 1'b0;
	logic REG_WR = 1'b0, REG_RD = 1'b0, FW_STORE = 1'b0, ENTER_DEBUG = 1'b0;
	logic [15:0] REG_ADDR = 16'h0000, INDEX_X = 16'hfefe;
	logic [7:0] REG_WDATA = 8'h00, CMD_SHIFT_DATA, REG_RDATA;
	logic DEBUG_PIN_FALL, DEBUG_CLK_TICK, CMD_SHIFT_DONE, SHIFT_START;
	logic SHIFT_DONE, SHIFT_OUT_VALID, SHIFT_IN_READY, DEBUG_ACTIVE, DEBUG_MAP;
	logic TAG_ENABLE, SERIAL_ENABLE, LINK_CLK_BUS, CMD_VALID, CMD_HW, CMD_DATA;
	logic CMD_READ, CMD_WORD, ENTER_BACKGROUND_REQUEST, DEBUG_MAP_SELECT;
	logic FW_RESUME, FW_SINGLE_STEP, FW_TAG_RESUME, TARGET_NEXT;
	logic [2:0] TARGET_REGISTER;
	logic [15:0] SHIFT_DATA, SHIFT_OUT_DATA, NEXT_ADDR;
	int n_errors = 0, tests_run = 0, cyc = 0;
	dbg_cmd_decode #(.IDLE_CYCLES(8)) dbg_cmd_decode_inst (.*);
	dbg_host dbg_host_inst (.*);
	always #5 CORE_CLK = ~CORE_CLK;
	always @(posedge CORE_CLK) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			wrap_up();
		end
	end
	// ========================================
	// Shared tasks
	task automatic wrap_up();
		if (n_errors == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic cmp(input logic [16:0] g, input logic [16:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic s);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		FW_STORE <= s;
		@(posedge CORE_CLK);
		REG_WR <= 1'b0;
		FW_STORE <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CORE_CLK);
		REG_RD <= 1'b0;
		#1 cmp(REG_RDATA, e);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge CORE_CLK);
		#1;
	endtask
	// ========================================
	// Scenarios
	task automatic s_reset();
		rd(16'hff01, 8'h00);
		wr(16'hff00, 8'h28, 1'b0);
		rd(16'hff00, 8'h28);
		rd(16'h1234, 8'h00);
	endtask
	task automatic s_hw();
		dbg_host_inst.cmd(8'hec, 2);
		#1 cmp({CMD_VALID, CMD_HW, CMD_DATA, CMD_READ}, 4'hf);
		cmp({ENTER_BACKGROUND_REQUEST, CMD_WORD, DEBUG_MAP_SELECT}, 3'h3);
		dbg_host_inst.cmd(8'h90, 1);
		#1 cmp({CMD_HW, ENTER_BACKGROUND_REQUEST, CMD_WORD}, 3'h6);
		wait_n(6);
		cmp(DEBUG_ACTIVE, 1'b0);
	endtask
	task automatic s_clk();
		wr(16'hff01, 8'h84, 1'b0);
		#1 cmp(LINK_CLK_BUS, 1'b0);
		dbg_host_inst.cmd(8'h90, 1);
		#1 cmp(LINK_CLK_BUS, 1'b1);
		wait_n(6);
		cmp({DEBUG_ACTIVE, DEBUG_MAP}, 2'h3);
		rd(16'hff01, 8'hc4);
		wr(16'hff01, 8'h80, 1'b0);
		dbg_host_inst.cmd(8'hc0, 0);
		#1 cmp({LINK_CLK_BUS, DEBUG_ACTIVE}, 2'h1);
		@(posedge CORE_CLK);
		BUS_CLK_SLOW <= 1'b1;
		wait_n(1);
		cmp(LINK_CLK_BUS, 1'b1);
		@(posedge CORE_CLK);
		BUS_CLK_SLOW <= 1'b0;
	endtask
	task automatic s_fw();
		logic [1:0] s;
		for (int i = 0; i < 8; i++) begin
			s = (i[1:0] == 2'h3) ? 2'h0 : i[1:0];
			dbg_host_inst.cmd({3'h0, s, i[2:0]}, 0);
			#1 cmp({FW_RESUME, FW_SINGLE_STEP}, {s == 1, s == 2});
			cmp({TARGET_NEXT, TARGET_REGISTER}, {i == 2, i[2:0]});
		end
		rd(16'hff01, 8'hc8);
		cmp(NEXT_ADDR, 16'hff00);
	endtask
	task automatic s_shift();
		fork
			dbg_host_inst.word(16'ha1a1, 6);
			rd(16'hff01, 8'hc8);
		join
		rd(16'hff01, 8'hd8);
		dbg_host_inst.word(16'hb2b2, 0);
		#1 cmp({SHIFT_IN_READY, SHIFT_OUT_VALID}, 2'h1);
		cmp(SHIFT_OUT_DATA, 16'ha1a1);
		@(posedge CORE_CLK);
		SHIFT_OUT_READY <= 1'b1;
		wait_n(1);
		cmp({SHIFT_OUT_VALID, SHIFT_OUT_DATA}, {1'b1, 16'hb2b2});
		@(posedge CORE_CLK);
		SHIFT_OUT_READY <= 1'b0;
		#1 cmp(SHIFT_OUT_VALID, 1'b0);
	endtask
	task automatic s_tag();
		int n;
		dbg_host_inst.cmd(8'h18, 0);
		#1 cmp(FW_TAG_RESUME, 1'b1);
		n = 0;
		while (TAG_ENABLE !== 1'b1 && n < 40) begin
			@(posedge CORE_CLK);
			#1 n++;
		end
		cmp(n >= 15 && n <= 17, 1'b1);
		cmp({SERIAL_ENABLE, SHIFT_IN_READY}, 2'h0);
		dbg_host_inst.cmd(8'hec, 0);
		#1 cmp(CMD_VALID, 1'b0);
		// Firmware leaves active mode before a breakpoint can re-enter it
		wr(16'hff01, 8'ha0, 1'b1);
		wait_n(4);
		cmp(DEBUG_ACTIVE, 1'b0);
		@(posedge CORE_CLK);
		ENTER_DEBUG <= 1'b1;
		@(posedge CORE_CLK);
		ENTER_DEBUG <= 1'b0;
		wait_n(3);
		cmp({TAG_ENABLE, SERIAL_ENABLE}, 2'h1);
		rd(16'hff01, 8'hc0);
		rd(16'hff00, 8'h18);
	endtask
	task automatic s_boot();
		@(posedge CORE_CLK);
		RST <= 1'b1;
		SPECIAL_SINGLE <= 1'b1;
		repeat (5) @(posedge CORE_CLK);
		RST <= 1'b0;
		#1 cmp({DEBUG_ACTIVE, DEBUG_MAP}, 2'h3);
		wait_n(1);
		cmp({DEBUG_ACTIVE, TAG_ENABLE, LINK_CLK_BUS}, 3'h0);
		@(posedge CORE_CLK);
		SPECIAL_SINGLE <= 1'b0;
		rd(16'hff01, 8'h00);
	endtask
	task automatic s_exit();
		wr(16'hff01, 8'h80, 1'b1);
		wait_n(2);
		cmp(DEBUG_ACTIVE, 1'b1);
		wait_n(4);
		cmp({DEBUG_ACTIVE, DEBUG_MAP}, 2'h0);
		dbg_host_inst.cmd(8'hec, 0);
		dbg_host_inst.ticks(6);
		rd(16'hff00, 8'hec);
		dbg_host_inst.ticks(2);
		rd(16'hff00, 8'h00);
	endtask
	initial begin
		repeat (5) @(posedge CORE_CLK);
		RST <= 1'b0;
		s_reset();
		s_hw();
		s_clk();
		s_fw();
		s_shift();
		s_tag();
		s_exit();
		s_boot();
		wrap_up();
	end
endmodule
`default_nettype wire
